//--- src/dscp_pkg.sv
// Purpose: Shared constants and types for the dual-channel converter serial config port.
// Assumes: 16-bit registers addressed by a 4-bit register index.
// Notes:   Every register offset, field bit and reset value, and every SPI or boot count, lives here.
package dscp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONFIG     = 4'h3;
  localparam logic [3:0]  ADDR_GAIN       = 4'h4;
  localparam logic [3:0]  ADDR_CODE_A     = 4'h8;
  localparam logic [3:0]  ADDR_CODE_B     = 4'h9;
  localparam logic [15:0] CFG_RESET       = 16'h0000;
  localparam logic [15:0] GAIN_RESET      = 16'h0000;
  localparam logic [15:0] CODE_ZERO       = 16'h0000;
  localparam logic [15:0] CODE_MID        = 16'h8000;
  localparam int          CFG_REF_OFF_BIT = 8;
  localparam int          GAIN_HALVE_BIT  = 8;
  localparam int          GAIN_A_BIT      = 0;
  localparam int          GAIN_B_BIT      = 1;
  // Full-resolution part keeps all bits; 14/12-bit parts would use 16'hFFFC or 16'hFFF0.
  localparam logic [15:0] CODE_KEEP_MASK  = 16'hFFFF;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam logic [4:0] SPI_FRAME_BITS = 5'd24;
  localparam logic [4:0] SPI_CNT_MAX    = 5'd31;
  localparam int         SPI_READ_BIT   = 23;
  localparam int         SPI_ADDR_LSB   = 16;
  localparam logic [4:0] I2C_ADDR_HI    = 5'h09;
  localparam logic [1:0] BOOT_LAST      = 2'd3;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SY_W     = 8;
  localparam int SY_SCLK  = 0;
  localparam int SY_SYNCN = 1;
  localparam int SY_SDIN  = 2;
  localparam int SY_SCL   = 3;
  localparam int SY_SDA   = 4;
  localparam int SY_STRAP = 5;
  localparam int SY_RSTLV = 6;
  localparam int SY_HEAD  = 7;

  typedef enum logic [5:0] {
    I2C_IDLE = 6'b000001,
    I2C_ADDR = 6'b000010,
    I2C_PTR  = 6'b000100,
    I2C_MSB  = 6'b001000,
    I2C_LSB  = 6'b010000,
    I2C_ACK  = 6'b100000
  } dscp_i2c_e;

  typedef struct packed {
    logic [1:0]  boot;
    logic        ready;
    logic        useI2c;
    logic [15:0] cfg;
    logic [15:0] gain;
    logic [15:0] codeA;
    logic [15:0] codeB;
    logic        outEn;
    logic [23:0] spiShift;
    logic [4:0]  spiCnt;
    dscp_i2c_e   i2cSt;
    dscp_i2c_e   i2cAfter;
    logic [7:0]  i2cShift;
    logic [2:0]  i2cCnt;
    logic        byteFull;
    logic [3:0]  i2cPtr;
    logic [7:0]  i2cHi;
    logic        sdaOe;
  } dscp_state_s;

endpackage : dscp_pkg

//--- src/dscp_sync.sv
// Purpose: Two-flop synchroniser plus one history stage for edge finding.
// Assumes: Inputs are asynchronous to mclk.
// Notes:   Only the second stage and the history stage are visible outside.
`timescale 1ns/1ps
module dscp_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,    // System clock.
  input  wire logic         sys_rst, // Asynchronous reset, active high.
  input  wire logic         clkEn,   // Freezes all stages while low.
  input  wire logic [W-1:0] d,       // Raw pin levels.
  output logic      [W-1:0] q,       // Synchronised levels.
  output logic      [W-1:0] qPrev    // Synchronised levels one cycle earlier.
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta  <= '0;
      q     <= '0;
      qPrev <= '0;
    end
    else if (clkEn)
    begin
      meta  <= d;
      q     <= meta;
      qPrev <= q;
    end
  end

endmodule : dscp_sync

//--- src/dscp_top.sv
// Purpose: Serial register front end (SPI or I2C) of a dual-channel converter.
// Assumes: Serial clocks are far slower than mclk; every pin except addressSelectPin is synchronised first.
// Notes:   Write-only register access on both ports; reads are not answered.
//
// Notes on behaviour
// [RQ1] Strap low selects SPI, high selects I2C.
// [RQ2] Outputs start at known level after power-up.
// [RQ3] Codes reset to zero or mid-scale by pin.
// [RQ4] SPI is clock, data-in, select; no data-out.
// [RQ5] Address pin picks one of four I2C addresses.
// [RQ6] Host disables internal reference first if external.
// [RQ7] Outputs off on low headroom unless halving set.
// [RQ8] Host order: reference, divider, gain, codes.
// [RQ9] SPI mode 1: idle low, capture falling edge.
// [RQ10] One low select per exact 24-bit packet.
// [RQ11] Config 0x0100 at 0x03 disables internal reference.
// [RQ12] Gain 0x0103 at 0x04 halves reference, gain two.
// [RQ13] Channel A at 0x08, channel B at 0x09.
// [RQ14] Codes straight binary, left aligned, low bits ignored; the code keeps all 16 bits (CODE_KEEP_MASK is 16'hFFFF).
// [RQ15] Frame is command byte, data word, MSB first.
`timescale 1ns/1ps
module dscp_top
  import dscp_pkg::*;
(
  input  wire logic        mclk,                // System clock, 25 MHz.
  input  wire logic        sys_rst,             // Asynchronous reset, active high.
  input  wire logic        clkEn,               // Clock enable; state frozen while low.
  input  wire logic        interfaceSelectStrap, // Low for SPI, high for I2C.
  input  wire logic        resetLevelSelect,    // Low zero code, high mid-scale.
  input  wire logic [1:0]  addressSelectPin,    // Encoded I2C address choice.
  input  wire logic        refHeadroomLow,      // Reference lacks supply headroom.
  input  wire logic        spiSclk,             // SPI clock from host.
  input  wire logic        spiSyncN,            // SPI frame select, active low.
  input  wire logic        spiSdin,             // SPI data in.
  input  wire logic        scl,                 // I2C clock.
  input  wire logic        sdaIn,               // I2C data level.
  output logic             sdaOut,              // I2C data drive value (always low).
  output logic             sdaOe,               // I2C data drive enable, high drives.
  output logic [15:0]      chanACode,           // Channel A code.
  output logic [15:0]      chanBCode,           // Channel B code.
  output logic             internalRefOff,      // Internal reference disabled.
  output logic             refHalve,            // Reference halving bit.
  output logic             gainDoubleA,         // Channel A gain of two.
  output logic             gainDoubleB,         // Channel B gain of two.
  output logic             outputsEnabled,      // Channel outputs active.
  output logic             serialReady,         // Port accepting traffic.
  output logic             i2cSelected          // Latched interface mode.
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [SY_W-1:0] pinRaw;
  logic [SY_W-1:0] sq;
  logic [SY_W-1:0] sp;

  assign pinRaw = {refHeadroomLow, resetLevelSelect, interfaceSelectStrap,
                   sdaIn, scl, spiSdin, spiSyncN, spiSclk};

  dscp_sync #(.W(SY_W)) uSync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .d       (pinRaw),
    .q       (sq),
    .qPrev   (sp)
  );

  logic sclkFall;
  logic syncFall;
  logic syncRise;
  logic sclRise;
  logic sclFall;
  logic i2cStart;
  logic i2cStop;

  assign sclkFall = sp[SY_SCLK] & ~sq[SY_SCLK];
  assign syncFall = sp[SY_SYNCN] & ~sq[SY_SYNCN];
  assign syncRise = ~sp[SY_SYNCN] & sq[SY_SYNCN];
  assign sclRise  = ~sp[SY_SCL] & sq[SY_SCL];
  assign sclFall  = sp[SY_SCL] & ~sq[SY_SCL];
  assign i2cStart = sq[SY_SCL] & sp[SY_SCL] & sp[SY_SDA] & ~sq[SY_SDA];
  assign i2cStop  = sq[SY_SCL] & sp[SY_SCL] & ~sp[SY_SDA] & sq[SY_SDA];

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  function automatic dscp_state_s writeReg(dscp_state_s s, logic [3:0] a, logic [15:0] d);
    dscp_state_s r;
    r = s;
    case (a)
      ADDR_CONFIG: r.cfg   = d;                     // [RQ11]
      ADDR_GAIN:   r.gain  = d;                     // [RQ12]
      ADDR_CODE_A: r.codeA = d & CODE_KEEP_MASK;    // [RQ13] [RQ14]
      ADDR_CODE_B: r.codeB = d & CODE_KEEP_MASK;    // [RQ13] [RQ14]
      default:     r = s;
    endcase
    return r;
  endfunction : writeReg

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  dscp_state_s st;
  dscp_state_s next_st;
  logic [6:0]  myAddr;

  assign myAddr = {I2C_ADDR_HI, addressSelectPin};  // [RQ5]

  always_comb
  begin
    next_st = st;
    if (clkEn)
    begin
      if (!st.ready)
      begin
        // Straps are caught only once the synchroniser has filled after reset.
        next_st.boot = st.boot + 2'd1;
        if (st.boot == BOOT_LAST)
        begin
          next_st.ready  = 1'b1;
          next_st.useI2c = sq[SY_STRAP];                       // [RQ1]
          next_st.codeA  = sq[SY_RSTLV] ? CODE_MID : CODE_ZERO; // [RQ2] [RQ3]
          next_st.codeB  = sq[SY_RSTLV] ? CODE_MID : CODE_ZERO; // [RQ2] [RQ3]
        end
      end
      else
      begin
        next_st.outEn = !(sq[SY_HEAD] && !st.gain[GAIN_HALVE_BIT]); // [RQ7]
        if (!st.useI2c)
        begin
          if (syncFall)
            next_st.spiCnt = 5'd0;
          else if (!sq[SY_SYNCN] && sclkFall)
          begin
            next_st.spiShift = {st.spiShift[22:0], sq[SY_SDIN]};    // [RQ9] [RQ15]
            if (st.spiCnt != SPI_CNT_MAX)
              next_st.spiCnt = st.spiCnt + 5'd1;
          end
          // Short or long frames are dropped whole rather than half applied.
          if (syncRise && st.spiCnt == SPI_FRAME_BITS && !st.spiShift[SPI_READ_BIT])
            next_st = writeReg(next_st, st.spiShift[SPI_ADDR_LSB+3:SPI_ADDR_LSB],
                               st.spiShift[15:0]);                 // [RQ10] [RQ15]
        end
        else if (i2cStart)
        begin
          next_st.i2cSt    = I2C_ADDR;
          next_st.i2cCnt   = 3'd0;
          next_st.byteFull = 1'b0;
          next_st.sdaOe    = 1'b0;
        end
        else if (i2cStop)
        begin
          next_st.i2cSt    = I2C_IDLE;
          next_st.byteFull = 1'b0;
          next_st.sdaOe    = 1'b0;
        end
        else if (sclRise && st.i2cSt != I2C_IDLE && st.i2cSt != I2C_ACK)
        begin
          next_st.i2cShift = {st.i2cShift[6:0], sq[SY_SDA]};
          next_st.i2cCnt   = st.i2cCnt + 3'd1;
          if (st.i2cCnt == 3'd7)
            next_st.byteFull = 1'b1;
        end
        else if (sclFall)
        begin
          if (st.i2cSt == I2C_ACK)
          begin
            next_st.sdaOe = 1'b0;
            next_st.i2cSt = st.i2cAfter;
          end
          else if (st.byteFull)
          begin
            next_st.byteFull = 1'b0;
            next_st.sdaOe    = 1'b1;
            next_st.i2cSt    = I2C_ACK;
            case (st.i2cSt)
              I2C_ADDR:
                if (st.i2cShift[7:1] == myAddr && !st.i2cShift[0]) // [RQ5]
                  next_st.i2cAfter = I2C_PTR;
                else
                begin
                  next_st.sdaOe = 1'b0;
                  next_st.i2cSt = I2C_IDLE;
                end
              I2C_PTR:
              begin
                next_st.i2cPtr   = st.i2cShift[3:0];
                next_st.i2cAfter = I2C_MSB;
              end
              I2C_MSB:
              begin
                next_st.i2cHi    = st.i2cShift;
                next_st.i2cAfter = I2C_LSB;
              end
              I2C_LSB:
              begin
                next_st          = writeReg(next_st, st.i2cPtr, {st.i2cHi, st.i2cShift});
                next_st.i2cAfter = I2C_MSB;
              end
              default:
              begin
                next_st.sdaOe = 1'b0;
                next_st.i2cSt = I2C_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st          <= '0;
      st.cfg      <= CFG_RESET;
      st.gain     <= GAIN_RESET;
      st.codeA    <= CODE_ZERO;
      st.codeB    <= CODE_ZERO;
      st.i2cSt    <= I2C_IDLE;
      st.i2cAfter <= I2C_IDLE;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The data line is open drain, so only the enable carries information.
  assign sdaOut         = 1'b0;
  assign sdaOe          = st.sdaOe;                           // [RQ4]
  assign chanACode      = st.codeA;
  assign chanBCode      = st.codeB;
  assign internalRefOff = st.cfg[CFG_REF_OFF_BIT];           // [RQ11]
  assign refHalve       = st.gain[GAIN_HALVE_BIT];           // [RQ12]
  assign gainDoubleA    = st.gain[GAIN_A_BIT];               // [RQ12]
  assign gainDoubleB    = st.gain[GAIN_B_BIT];               // [RQ12]
  assign outputsEnabled = st.outEn;
  assign serialReady    = st.ready;
  assign i2cSelected    = st.useI2c;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic spiCommit;
  assign spiCommit = clkEn && st.ready && !st.useI2c && syncRise
                     && st.spiCnt == SPI_FRAME_BITS && !st.spiShift[SPI_READ_BIT];

  mode_latch_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ1]
    $rose(st.ready) |-> st.useI2c == $past(sq[SY_STRAP]))
    else $error("interface mode not taken from strap");

  reset_code_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ3]
    $rose(st.ready) |-> st.codeA == ($past(sq[SY_RSTLV]) ? CODE_MID : CODE_ZERO)
                        && st.codeB == st.codeA)
    else $error("reset code does not follow level select");

  spi_no_drive_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ4]
    !st.useI2c |-> !sdaOe)
    else $error("data line driven in SPI mode");

  head_gate_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ7]
    (clkEn && st.ready && sq[SY_HEAD] && !st.gain[GAIN_HALVE_BIT]) |=> !outputsEnabled)
    else $error("outputs enabled without headroom");

  mode1_shift_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ9]
    (!st.useI2c && st.spiCnt != $past(st.spiCnt) && st.spiCnt != 5'd0)
      |-> $past(sclkFall) && !$past(sq[SY_SYNCN]))
    else $error("bit counted off the falling clock edge");

  short_frame_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ10]
    (clkEn && st.ready && !st.useI2c && syncRise && st.spiCnt != SPI_FRAME_BITS)
      |=> $stable(st.codeA) && $stable(st.codeB) && $stable(st.cfg) && $stable(st.gain))
    else $error("register changed by a frame not 24 bits long");

  code_a_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ13]
    (spiCommit && st.spiShift[19:16] == ADDR_CODE_A)
      |=> chanACode == $past(st.spiShift[15:0]))
    else $error("channel A code not written");

  ref_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ11]
    (spiCommit && st.spiShift[19:0] == {ADDR_CONFIG, 16'h0100}) |=> internalRefOff)
    else $error("internal reference not disabled");

  gain_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ12]
    (spiCommit && st.spiShift[19:0] == {ADDR_GAIN, 16'h0103})
      |=> refHalve && gainDoubleA && gainDoubleB)
    else $error("gain write did not take effect");

  i2c_ack_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RQ5]
    (clkEn && st.useI2c && st.i2cSt == I2C_ADDR && st.byteFull && sclFall && !i2cStart
      && !i2cStop) |=> sdaOe == (st.i2cSt == I2C_ACK) && sdaOe == ($past(st.i2cShift) ==
      {myAddr, 1'b0}))
    else $error("address acknowledge wrong");

  spi_commit_c: cover property (@(posedge mclk) disable iff (sys_rst) spiCommit);
  i2c_write_c:  cover property (@(posedge mclk) disable iff (sys_rst)
    st.i2cSt == I2C_LSB && sclFall && st.byteFull);
  head_off_c:   cover property (@(posedge mclk) disable iff (sys_rst)
    st.ready && !outputsEnabled);

endmodule : dscp_top

//--- verif/dscp_host.sv
// Purpose: Host processor model that drives the SPI or I2C side of the config port.
// Assumes: Paced by falling mclk edges; the host owns both serial clocks.
// Notes:   Serial clocks stand still between frames; SPI data shows its inverse when idle.
`timescale 1ns/1ps
module dscp_host (
  input  wire logic mclk,     // System clock used for pacing.
  input  wire logic sda,      // Resolved I2C data level.
  output logic      spiSclk,  // SPI clock, idles low.
  output logic      spiSyncN, // SPI frame select, active low.
  output logic      spiSdin,  // SPI data to the device.
  output logic      scl,      // I2C clock.
  output logic      sdaLow    // High pulls I2C data low.
);
  localparam int HALF = 4;

  initial
  begin
    spiSclk  = 1'b0;
    spiSyncN = 1'b1;
    spiSdin  = 1'b0;
    scl      = 1'b1;
    sdaLow   = 1'b0;
  end

  task automatic pace(input int n);
    repeat (n) @(negedge mclk);
  endtask : pace

  // ----------------------------------------------------------------
  // SPI
  // ----------------------------------------------------------------
  // A count other than 24 is only used to provoke a refusal.
  task automatic spiFrame(input logic [23:0] f, input int n);
    int i;
    spiSyncN = 1'b0;
    pace(HALF);
    for (i = 0; i < n; i++)
    begin
      spiSclk = 1'b1;
      spiSdin = (i < 24) ? f[23-i] : 1'b0;
      pace(HALF);
      spiSclk = 1'b0;
      pace(HALF);
    end
    spiSyncN = 1'b1;
    spiSdin  = ~spiSdin;
    pace(12);
  endtask : spiFrame

  // ----------------------------------------------------------------
  // I2C
  // ----------------------------------------------------------------
  task automatic i2cByte(input logic [7:0] b, output logic ack);
    int i;
    for (i = 7; i >= 0; i--)
    begin
      sdaLow = ~b[i];
      pace(HALF);
      scl = 1'b1;
      pace(2 * HALF);
      scl = 1'b0;
      pace(HALF);
    end
    sdaLow = 1'b0;
    pace(HALF);
    scl = 1'b1;
    pace(2 * HALF);
    ack = ~sda;
    scl = 1'b0;
    pace(HALF);
  endtask : i2cByte

  task automatic i2cWrite(input logic [6:0] addr, input logic [3:0] idx,
                          input logic [15:0] data, output logic ack);
    logic a;
    sdaLow = 1'b1;
    pace(HALF);
    scl = 1'b0;
    pace(HALF);
    i2cByte({addr, 1'b0}, ack);
    if (ack)
    begin
      i2cByte({4'h0, idx}, a);
      i2cByte(data[15:8], a);
      i2cByte(data[7:0], a);
    end
    sdaLow = 1'b1;
    pace(HALF);
    scl = 1'b1;
    pace(HALF);
    sdaLow = 1'b0;
    pace(2 * HALF);
  endtask : i2cWrite
endmodule : dscp_host

//--- verif/dual_dac_serial_config_port_test.sv
// Purpose: Self-checking bench for the serial config port in both interface modes.
// Assumes: Inputs change at falling mclk edges; the host model paces all serial traffic.
// Notes:   One frame is sent with the clock enable low and must leave no trace.
`timescale 1ns/1ps
module dual_dac_serial_config_port_test
  import dscp_pkg::*;
;
  logic        mclk, sys_rst, strap, lvl, headroomLow, clkEn;
  logic [1:0]  addrPin;
  logic        spiSclk, spiSyncN, spiSdin, scl, sdaLow, sdaIn, sdaOut, sdaOe;
  logic [15:0] chanACode, chanBCode;
  logic        refOff, refHalve, gainA, gainB, outEn, serialReady, i2cSel, ack;
  int          mismatches, num_checks, p;

  // Open-drain data line with a pull-up: low if any party drives.
  assign sdaIn = ~(sdaLow | (sdaOe & ~sdaOut));

  dscp_top uut (
    .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .interfaceSelectStrap(strap),
    .resetLevelSelect(lvl), .addressSelectPin(addrPin), .refHeadroomLow(headroomLow),
    .spiSclk(spiSclk), .spiSyncN(spiSyncN), .spiSdin(spiSdin), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .chanACode(chanACode), .chanBCode(chanBCode),
    .internalRefOff(refOff), .refHalve(refHalve), .gainDoubleA(gainA),
    .gainDoubleB(gainB), .outputsEnabled(outEn), .serialReady(serialReady),
    .i2cSelected(i2cSel)
  );

  dscp_host host (
    .mclk(mclk), .sda(sdaIn), .spiSclk(spiSclk), .spiSyncN(spiSyncN),
    .spiSdin(spiSdin), .scl(scl), .sdaLow(sdaLow)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Strap and level pins are held well before release so they are caught stably.
  task automatic doReset(input logic s, input logic l);
    int n;
    sys_rst = 1'b1;
    strap   = s;
    lvl     = l;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    n = 0;
    while (serialReady !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 50)
    begin
      mismatches++;
      give_verdict();
    end
    repeat (3) @(negedge mclk);
  endtask : doReset

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    host.spiFrame({4'h0, idx, d}, 24);
  endtask : wr

  initial
  begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    mismatches  = 0;
    num_checks  = 0;
    sys_rst     = 1'b1;
    strap       = 1'b0;
    lvl         = 1'b1;
    addrPin     = 2'd0;
    headroomLow = 1'b0;
    clkEn       = 1'b1;
    // ----------------------------------------------------------------
    // SPI mode, mid-scale start
    // ----------------------------------------------------------------
    doReset(1'b0, 1'b1);
    check("codeA reset", chanACode, CODE_MID);
    check("codeB reset", chanBCode, CODE_MID);
    check("mode", {15'h0, i2cSel}, 16'h0000);
    wr(ADDR_CONFIG, 16'h0100);
    check("refOff", {15'h0, refOff}, 16'h0001);
    headroomLow = 1'b1;
    repeat (8) @(negedge mclk);
    check("outEn low", {15'h0, outEn}, 16'h0000);
    wr(ADDR_GAIN, 16'h0103);
    check("gain", {13'h0, refHalve, gainB, gainA}, 16'h0007);
    check("outEn halved", {15'h0, outEn}, 16'h0001);
    wr(ADDR_CODE_A, 16'h7FFF);
    wr(ADDR_CODE_B, 16'hFFFF);
    check("codeA", chanACode, 16'h7FFF);
    check("codeB", chanBCode, 16'hFFFF);
    host.spiFrame({4'h0, ADDR_CODE_A, 16'h1234}, 23);
    check("short frame", chanACode, 16'h7FFF);
    host.spiFrame({4'h0, ADDR_CODE_A, 16'h1234}, 25);
    check("long frame", chanACode, 16'h7FFF);
    host.spiFrame({4'h8, ADDR_CODE_A, 16'h1234}, 24);
    check("read frame", chanACode, 16'h7FFF);
    wr(4'h5, 16'h1234);
    check("unmapped A", chanACode, 16'h7FFF);
    check("unmapped B", chanBCode, 16'hFFFF);
    wr(ADDR_CODE_B, 16'h8001);
    check("bit order", chanBCode, 16'h8001);
    check("no drive", {15'h0, sdaOe}, 16'h0000);
    // With the enable low the synchroniser is frozen too, so the whole frame is missed.
    clkEn = 1'b0;
    wr(ADDR_CODE_B, 16'h1111);
    clkEn = 1'b1;
    repeat (4) @(negedge mclk);
    check("frozen codeB", chanBCode, 16'h8001);
    // ----------------------------------------------------------------
    // I2C mode, zero start
    // ----------------------------------------------------------------
    doReset(1'b1, 1'b0);
    check("codeA zero", chanACode, CODE_ZERO);
    check("codeB zero", chanBCode, CODE_ZERO);
    check("sda value", {15'h0, sdaOut}, 16'h0000);
    check("mode i2c", {15'h0, i2cSel}, 16'h0001);
    check("outEn reset", {15'h0, outEn}, 16'h0000);
    wr(ADDR_CODE_A, 16'hABCD);
    check("spi ignored", chanACode, CODE_ZERO);
    for (p = 0; p < 4; p++)
    begin
      addrPin = p[1:0];
      host.i2cWrite({I2C_ADDR_HI, p[1:0]}, ADDR_CODE_B, {p[3:0], 12'h5A3}, ack);
      check("ack match", {15'h0, ack}, 16'h0001);
      check("i2c codeB", chanBCode, {p[3:0], 12'h5A3});
      host.i2cWrite({I2C_ADDR_HI, p[1:0] ^ 2'd1}, ADDR_CODE_B, 16'h0F0F, ack);
      check("ack other", {15'h0, ack}, 16'h0000);
      check("kept codeB", chanBCode, {p[3:0], 12'h5A3});
    end
    give_verdict();
  end
endmodule : dual_dac_serial_config_port_test
